// >>> rtl/cocr_pkg.sv
// Package for the clock output control register bank.
package cocr_pkg;

  localparam logic [7:0] IDX_PIN_READBACK = 8'h00;
  localparam logic [7:0] IDX_PAIR_STOP_EN = 8'h01;
  localparam logic [7:0] IDX_PAIR_DRIVE   = 8'h02;
  localparam logic [7:0] IDX_BUS_CLK_CTRL = 8'h03;
  localparam logic [7:0] IDX_BYTE_COUNT   = 8'h08;

  localparam logic [7:0] RST_PAIR_STOP_EN = 8'h7f;
  localparam logic [7:0] RST_PAIR_DRIVE   = 8'h00;
  localparam logic [7:0] RST_BUS_CLK_CTRL = 8'hff;
  localparam logic [7:0] RST_BYTE_COUNT   = 8'h08;

  localparam int BIT_REF_STOPPABLE = 7;
  localparam int BIT_REF_ENABLE    = 6;
  localparam int LSB_CORE_STOPPABLE = 3;
  localparam int LSB_CORE_ENABLE    = 0;
  localparam int BIT_REF_PD_TRI    = 7;
  localparam int BIT_REF_HALT_TRI  = 6;
  localparam int LSB_CORE_PD_TRI   = 3;
  localparam int LSB_CORE_HALT_TRI = 0;
  localparam int BIT_SW_BUS_RUN    = 7;
  localparam int CORE_PAIRS        = 3;
  localparam int BUS_CLOCKS        = 7;

  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h69;
  localparam logic [2:0] LAST_BIT         = 3'h7;

  typedef enum {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TACK} cocr_state_e;

  typedef struct packed {
    logic                  ref_run;
    logic                  ref_drive;
    logic [CORE_PAIRS-1:0] core_run;
    logic [CORE_PAIRS-1:0] core_drive;
    logic [BUS_CLOCKS-1:0] bus_run;
  } cocr_outputs_s;

endpackage : cocr_pkg

// >>> rtl/cocr_top.sv
// Control register bank bytes 0 to 3 and 8 with its two-wire serial slave.
`timescale 1ns/1ps
`default_nettype none
module cocr_top
  import cocr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  input  wire logic                  MCLK_I,
  input  wire logic                  NRST_I,
  input  wire logic                  SCLK_I,
  input  wire logic                  SDATA_I,
  output logic                       SDATA_O,
  output logic                       SDATA_OE_O,
  input  wire logic                  BUS_HALT_N_I,
  input  wire logic                  CORE_HALT_N_I,
  input  wire logic                  POWER_DOWN_N_I,
  input  wire logic                  FREQ_STRAP_LOW_I,
  input  wire logic                  FREQ_STRAP_HIGH_I,
  output logic                       REF_PAIR_RUN_O,
  output logic                       REF_PAIR_DRIVE_O,
  output logic [CORE_PAIRS-1:0]      CORE_PAIR_RUN_O,
  output logic [CORE_PAIRS-1:0]      CORE_PAIR_DRIVE_O,
  output logic [BUS_CLOCKS-1:0]      BUS_CLOCK_RUN_O
);

  logic [6:0]    sync1_q;
  logic [6:0]    sync2_q;
  logic [1:0]    link_prev_q;
  logic          scl;
  logic          sda;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_ev;
  logic          stop_ev;
  logic [7:0]    stop_en_q;
  logic [7:0]    drive_q;
  logic [7:0]    bus_ctrl_q;
  logic [7:0]    count_q;
  logic [7:0]    readback;
  logic [7:0]    rd_data;
  cocr_state_e   state_q;
  logic [2:0]    bit_q;
  logic [7:0]    shift_q;
  logic [1:0]    rx_phase_q;
  logic          read_q;
  logic          ack_drv_q;
  logic          sda_low_q;
  logic [7:0]    ptr_q;
  logic [7:0]    tx_left_q;
  logic [7:0]    rx_byte;
  cocr_outputs_s out_q;

  // Link and pin inputs cross into the master clock domain through two stages.
  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      sync1_q <= 7'h7f;
      sync2_q <= 7'h7f;
    end else begin
      sync1_q <= {FREQ_STRAP_HIGH_I, FREQ_STRAP_LOW_I, POWER_DOWN_N_I, CORE_HALT_N_I,
                  BUS_HALT_N_I, SDATA_I, SCLK_I};
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      link_prev_q <= 2'h3;
    end else begin
      link_prev_q <= sync2_q[1:0];
    end
  end

  assign scl      = sync2_q[0];
  assign sda      = sync2_q[1];
  assign scl_rise = scl & ~link_prev_q[0];
  assign scl_fall = ~scl & link_prev_q[0];
  assign start_ev = scl & link_prev_q[0] & ~sda & link_prev_q[1];
  assign stop_ev  = scl & link_prev_q[0] & sda & ~link_prev_q[1];
  assign rx_byte  = {shift_q[6:0], sda};

  // Live levels of the halt inputs and straps; upper bits read zero.
  assign readback = {4'h0, sync2_q[2], sync2_q[3], sync2_q[6], sync2_q[5]};

  // Read multiplexer for the byte at the current pointer.
  always_comb begin
    case (ptr_q)
      IDX_PIN_READBACK: rd_data = readback;
      IDX_PAIR_STOP_EN: rd_data = stop_en_q;
      IDX_PAIR_DRIVE:   rd_data = drive_q;
      IDX_BUS_CLK_CTRL: rd_data = bus_ctrl_q;
      IDX_BYTE_COUNT:   rd_data = count_q;
      default:          rd_data = 8'h00;
    endcase
  end

  // Serial slave: address, command index, block count, then data bytes.
  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      state_q    <= ST_IDLE;
      bit_q      <= 3'h0;
      shift_q    <= 8'h00;
      rx_phase_q <= 2'h0;
      read_q     <= 1'b0;
      ack_drv_q  <= 1'b0;
      sda_low_q  <= 1'b0;
      ptr_q      <= 8'h00;
      tx_left_q  <= 8'h00;
    end else if (start_ev) begin
      state_q    <= ST_RX;
      bit_q      <= 3'h0;
      rx_phase_q <= 2'h0;
      sda_low_q  <= 1'b0;
    end else if (stop_ev) begin
      state_q   <= ST_IDLE;
      sda_low_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          sda_low_q <= 1'b0;
        end
        ST_RX: begin
          if (scl_rise) begin
            shift_q <= rx_byte;
            bit_q   <= bit_q + 3'h1;
            if (bit_q == LAST_BIT) begin
              ack_drv_q <= 1'b0;
              state_q   <= ST_ACK;
              if (rx_phase_q == 2'h0) begin
                read_q <= rx_byte[0];
                if (rx_byte[7:1] != DEV_ADDR) begin
                  state_q <= ST_IDLE;
                end
                tx_left_q <= count_q;
              end else if (rx_phase_q == 2'h1) begin
                ptr_q <= rx_byte;
              end else if (rx_phase_q == 2'h3) begin
                ptr_q <= ptr_q + 8'h01;
              end
              if (rx_phase_q != 2'h3) begin
                rx_phase_q <= rx_phase_q + 2'h1;
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (!ack_drv_q) begin
              ack_drv_q <= 1'b1;
              sda_low_q <= 1'b1;
            end else if (read_q) begin
              shift_q   <= count_q;
              sda_low_q <= ~count_q[7];
              bit_q     <= 3'h0;
              state_q   <= ST_TX;
            end else begin
              sda_low_q <= 1'b0;
              bit_q     <= 3'h0;
              state_q   <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            bit_q <= bit_q + 3'h1;
            if (bit_q == LAST_BIT) begin
              sda_low_q <= 1'b0;
              state_q   <= ST_TACK;
            end else begin
              shift_q   <= {shift_q[6:0], 1'b0};
              sda_low_q <= ~shift_q[6];
            end
          end
        end
        ST_TACK: begin
          if (scl_rise && sda) begin
            state_q <= ST_IDLE;
          end else if (scl_fall) begin
            if (tx_left_q == 8'h00) begin
              state_q <= ST_IDLE;
            end else begin
              shift_q   <= rd_data;
              sda_low_q <= ~rd_data[7];
              ptr_q     <= ptr_q + 8'h01;
              tx_left_q <= tx_left_q - 8'h01;
              bit_q     <= 3'h0;
              state_q   <= ST_TX;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Register writes on each completed data byte; byte 0 and unknown indices drop.
  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      stop_en_q  <= RST_PAIR_STOP_EN;
      drive_q    <= RST_PAIR_DRIVE;
      bus_ctrl_q <= RST_BUS_CLK_CTRL;
      count_q    <= RST_BYTE_COUNT;
    end else if (state_q == ST_RX && !start_ev && !stop_ev && scl_rise
                 && bit_q == LAST_BIT && rx_phase_q == 2'h3) begin
      case (ptr_q)
        IDX_PAIR_STOP_EN: stop_en_q  <= rx_byte;
        IDX_PAIR_DRIVE:   drive_q    <= rx_byte;
        IDX_BUS_CLK_CTRL: bus_ctrl_q <= rx_byte;
        IDX_BYTE_COUNT:   count_q    <= rx_byte;
        default:          count_q    <= count_q;
      endcase
    end
  end

  // Output gating from enables, stop modes, halt inputs and power-down.
  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      out_q <= '0;
    end else begin
      out_q.ref_run <= stop_en_q[BIT_REF_ENABLE] & sync2_q[4]
                     & ~(stop_en_q[BIT_REF_STOPPABLE]
                         & (~sync2_q[2] | ~bus_ctrl_q[BIT_SW_BUS_RUN]));
      out_q.ref_drive <= ~(~sync2_q[4] & drive_q[BIT_REF_PD_TRI])
                       & ~(stop_en_q[BIT_REF_STOPPABLE] & drive_q[BIT_REF_HALT_TRI]
                           & (~sync2_q[2] | ~bus_ctrl_q[BIT_SW_BUS_RUN]));
      for (int i = 0; i < CORE_PAIRS; i++) begin
        out_q.core_run[i] <= stop_en_q[LSB_CORE_ENABLE + i] & sync2_q[4]
                           & ~(stop_en_q[LSB_CORE_STOPPABLE + i] & ~sync2_q[3]);
        out_q.core_drive[i] <= ~(~sync2_q[4] & drive_q[LSB_CORE_PD_TRI + i])
                             & ~(stop_en_q[LSB_CORE_STOPPABLE + i] & ~sync2_q[3]
                                 & drive_q[LSB_CORE_HALT_TRI + i]);
      end
      for (int j = 0; j < BUS_CLOCKS; j++) begin
        out_q.bus_run[j] <= bus_ctrl_q[j] & sync2_q[4] & sync2_q[2]
                          & bus_ctrl_q[BIT_SW_BUS_RUN];
      end
    end
  end

  assign SDATA_O           = 1'b0;
  assign SDATA_OE_O        = sda_low_q;
  assign REF_PAIR_RUN_O    = out_q.ref_run;
  assign REF_PAIR_DRIVE_O  = out_q.ref_drive;
  assign CORE_PAIR_RUN_O   = out_q.core_run;
  assign CORE_PAIR_DRIVE_O = out_q.core_drive;
  assign BUS_CLOCK_RUN_O   = out_q.bus_run;

endmodule : cocr_top
`default_nettype wire

// >>> verif/cocr_host.sv
// Two-wire host model driving the link clock and data line.
`timescale 1ns/1ps
`default_nettype none
module cocr_host
  import cocr_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      sda_i,
  output var logic       scl_o = 1'b1,
  output var logic       sda_low_o = 1'b0,
  output var logic       stb_o = 1'b0,
  output var logic [7:0] byte_o = 8'h00,
  output var logic [7:0] nak_o = 8'h00
);
  localparam logic [7:0] ADR_W = {DEV_ADDR_DEFAULT, 1'b0};
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt
  task automatic bit_io(input logic b, output logic q);
    wt(1);
    sda_low_o <= ~b;
    wt(3);
    scl_o <= 1'b1;
    wt(4);
    q = sda_i;
    scl_o <= 1'b0;
  endtask : bit_io
  task automatic start();
    wt(1);
    sda_low_o <= 1'b0;
    wt(3);
    scl_o <= 1'b1;
    wt(4);
    sda_low_o <= 1'b1;
    wt(4);
    scl_o <= 1'b0;
  endtask : start
  task automatic stop();
    wt(1);
    sda_low_o <= 1'b1;
    wt(3);
    scl_o <= 1'b1;
    wt(4);
    sda_low_o <= 1'b0;
    wt(4);
  endtask : stop
  task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] q,
                      output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ack, a);
  endtask : xfer
  task automatic send(input logic [7:0] d);
    logic [7:0] q;
    logic       a;
    xfer(d, 1'b1, q, a);
    nak_o = nak_o + {7'h0, a};
  endtask : send
  task automatic wr(input logic [7:0] idx, input int n, input logic [31:0] d);
    start();
    send(ADR_W);
    send(idx);
    send(8'(n));
    for (int i = 0; i < n; i++) send(d[31-8*i -: 8]);
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] idx, input int n);
    logic [7:0] q;
    logic       a;
    start();
    send(ADR_W);
    send(idx);
    start();
    send(ADR_W | 8'h01);
    for (int i = 0; i <= n; i++) begin
      xfer(8'hff, i == n, q, a);
      byte_o <= q;
      stb_o <= 1'b1;
      wt(1);
      stb_o <= 1'b0;
    end
    stop();
  endtask : rd
endmodule : cocr_host
`default_nettype wire

// >>> verif/cocr_top_asserts.sv
// Concurrent checks on the control bank's ports.
`timescale 1ns/1ps
`default_nettype none
module cocr_top_asserts
  import cocr_pkg::*;
(
  input wire logic                  MCLK_I,
  input wire logic                  NRST_I,
  input wire logic                  SCLK_I,
  input wire logic                  SDATA_O,
  input wire logic                  SDATA_OE_O,
  input wire logic                  BUS_HALT_N_I,
  input wire logic                  CORE_HALT_N_I,
  input wire logic                  POWER_DOWN_N_I,
  input wire logic                  REF_PAIR_RUN_O,
  input wire logic [CORE_PAIRS-1:0] CORE_PAIR_RUN_O,
  input wire logic [CORE_PAIRS-1:0] CORE_PAIR_DRIVE_O,
  input wire logic [BUS_CLOCKS-1:0] BUS_CLOCK_RUN_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!NRST_I);
  a_pd_bus_off: assert property (!POWER_DOWN_N_I [*4] |-> BUS_CLOCK_RUN_O == '0)
    else $error("bus clock runs in power down");
  a_pd_core_off: assert property (!POWER_DOWN_N_I [*4] |-> CORE_PAIR_RUN_O == '0)
    else $error("core pair runs in power down");
  a_pd_ref_off: assert property (!POWER_DOWN_N_I [*4] |-> !REF_PAIR_RUN_O)
    else $error("reference pair runs in power down");
  a_halt_bus_off: assert property (!BUS_HALT_N_I [*4] |-> BUS_CLOCK_RUN_O == '0)
    else $error("bus clock runs while halted");
  a_core_driven: assert property ((POWER_DOWN_N_I && CORE_HALT_N_I) [*5]
    |-> &CORE_PAIR_DRIVE_O)
    else $error("core pair floats while running");
  a_run_needs_pd: assert property (|BUS_CLOCK_RUN_O |-> $past(POWER_DOWN_N_I, 2)
    || $past(POWER_DOWN_N_I, 3) || $past(POWER_DOWN_N_I, 4))
    else $error("bus clock runs without power");
  a_idle_release: assert property (SCLK_I [*8] |-> !SDATA_OE_O)
    else $error("data held low while link idle");
  a_open_drain: assert property (SDATA_O == 1'b0)
    else $error("data output drives high");
  a_data_steady: assert property ($changed(SDATA_OE_O) |-> !SCLK_I)
    else $error("data line moves while link clock high");
endmodule : cocr_top_asserts
`default_nettype wire

// >>> verif/cocr_top_tb.sv
// Self-checking bench for the clock output control bank.
`timescale 1ns/1ps
`default_nettype none
module cocr_top_tb;
  import cocr_pkg::*;
  logic          mclk = 1'b0;
  logic          nrst = 1'b0;
  logic          bh_n = 1'b1;
  logic          ch_n = 1'b1;
  logic          pd_n = 1'b1;
  logic          fs_lo = 1'b0;
  logic          fs_hi = 1'b0;
  logic          out_stb = 1'b0;
  logic          sda_oe, sda_o, scl, h_low, h_stb;
  logic [7:0]    h_byte, h_nak, b1, b2, b3, exp_b[$];
  logic [31:0]   seed, r;
  wire cocr_outputs_s got_o;
  cocr_outputs_s exp_o[$];
  int            checks = 0;
  int            miscompares = 0;
  wire logic     sda = (sda_oe ? sda_o : 1'b1) & ~h_low;
  initial forever #50 mclk = ~mclk;
  cocr_host u_host (.clk_i(mclk), .sda_i(sda), .scl_o(scl), .sda_low_o(h_low),
    .stb_o(h_stb), .byte_o(h_byte), .nak_o(h_nak));
  cocr_top DUT (.MCLK_I(mclk), .NRST_I(nrst), .SCLK_I(scl), .SDATA_I(sda),
    .SDATA_O(sda_o), .SDATA_OE_O(sda_oe), .BUS_HALT_N_I(bh_n), .CORE_HALT_N_I(ch_n),
    .POWER_DOWN_N_I(pd_n), .FREQ_STRAP_LOW_I(fs_lo), .FREQ_STRAP_HIGH_I(fs_hi),
    .REF_PAIR_RUN_O(got_o.ref_run), .REF_PAIR_DRIVE_O(got_o.ref_drive),
    .CORE_PAIR_RUN_O(got_o.core_run), .CORE_PAIR_DRIVE_O(got_o.core_drive),
    .BUS_CLOCK_RUN_O(got_o.bus_run));
  function automatic cocr_outputs_s calc();
    cocr_outputs_s e;
    logic          hlt;
    hlt = ~bh_n | ~b3[7];
    e.bus_run = b3[6:0] & {7{b3[7] & bh_n & pd_n}};
    e.ref_run = b1[6] & pd_n & ~(b1[7] & hlt);
    e.ref_drive = ~(~pd_n & b2[7]) & ~(b1[7] & b2[6] & hlt);
    e.core_run = b1[2:0] & {3{pd_n}} & ~(b1[5:3] & {3{~ch_n}});
    e.core_drive = ~({3{~pd_n}} & b2[5:3]) & ~(b1[5:3] & {3{~ch_n}} & b2[2:0]);
    return e;
  endfunction : calc
  task automatic e4(input logic [31:0] v);
    for (int i = 3; i >= 0; i--) exp_b.push_back(v[8*i +: 8]);
  endtask : e4
  task automatic cmp_b(input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD read_byte exp %h got %h", e, g);
    end
  endtask : cmp_b
  task automatic cmp_o(input cocr_outputs_s e);
    checks++;
    if (got_o !== e) begin
      miscompares++;
      $display("BAD outputs exp %h got %h", e, got_o);
    end
  endtask : cmp_o
  task automatic close_out();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  always @(posedge mclk) begin
    if (h_stb === 1'b1) cmp_b(exp_b.pop_front(), h_byte);
    if (out_stb === 1'b1) cmp_o(exp_o.pop_front());
  end
  initial begin
    #5_000_000;
    miscompares++;
    close_out();
  end
  initial begin
    seed = 32'h69c2;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    e4(32'h087f00ff);
    e4(32'h0);
    exp_b.push_back(8'h08);
    u_host.rd(IDX_PAIR_STOP_EN, 8);
    $display("test reset values done");
    u_host.wr(IDX_BYTE_COUNT, 1, 32'h03000000);
    for (int k = 0; k < 6; k++) begin
      r = $random(seed);
      {b1, b2, b3} = r[23:0];
      {bh_n, ch_n, pd_n, fs_hi, fs_lo} <= r[28:24] | {2'b00, k[0], 2'b00};
      u_host.wr(IDX_PIN_READBACK, 4, {r[31:24], b1, b2, b3});
      repeat (8) @(posedge mclk);
      exp_o.push_back(calc());
      out_stb <= 1'b1;
      @(posedge mclk);
      out_stb <= 1'b0;
      e4({8'h03, 4'h0, bh_n, ch_n, fs_hi, fs_lo, b1, b2});
      u_host.rd(IDX_PIN_READBACK, 3);
      e4({8'h03, b3, 16'h0});
      u_host.rd(IDX_BUS_CLK_CTRL, 3);
    end
    cmp_b(8'h00, h_nak);
    $display("test register traffic done");
    close_out();
  end
endmodule : cocr_top_tb
bind cocr_top cocr_top_asserts u_chk (.MCLK_I(MCLK_I), .NRST_I(NRST_I), .SCLK_I(SCLK_I),
  .SDATA_O(SDATA_O), .SDATA_OE_O(SDATA_OE_O), .BUS_HALT_N_I(BUS_HALT_N_I),
  .CORE_HALT_N_I(CORE_HALT_N_I), .POWER_DOWN_N_I(POWER_DOWN_N_I),
  .REF_PAIR_RUN_O(REF_PAIR_RUN_O), .CORE_PAIR_RUN_O(CORE_PAIR_RUN_O),
  .CORE_PAIR_DRIVE_O(CORE_PAIR_DRIVE_O), .BUS_CLOCK_RUN_O(BUS_CLOCK_RUN_O));
`default_nettype wire
